// File: rtl/pecr_defs.vh
/*
 * pecr_defs.vh: offsets, field positions, reset values and encodings
 * for the extended control and error counter registers (19 to 24).
 * Assumes inclusion by the register bank only; definitions only.
 */
`ifndef PECR_DEFS_VH
`define PECR_DEFS_VH

// register addresses
`define PECR_ADDR_RXERR_CNT   5'h13
`define PECR_ADDR_FCAR_CNT    5'h14
`define PECR_ADDR_LDISC_CNT   5'h15
`define PECR_ADDR_TEN_CTRL    5'h16
`define PECR_ADDR_MAC_CTRL    5'h17
`define PECR_ADDR_EDGE_CTRL   5'h18

// counter layout
`define PECR_CNT_W            8
`define PECR_CNT_MAX          8'hff
`define PECR_CNT_RST          8'h00

// ten_base_control_status bits
`define PECR_TEN_FORCE_LINK   15
`define PECR_TEN_JABBER_DIS   14
`define PECR_TEN_ECHO_DIS     13
`define PECR_TEN_SQE_DIS      12
`define PECR_TEN_SQUELCH_HI   11
`define PECR_TEN_SQUELCH_LO   10
`define PECR_TEN_STICKY_EN    9
`define PECR_TEN_EOF_ERR      8
`define PECR_TEN_DISC         7
`define PECR_TEN_LINK         6
`define PECR_TEN_BCAST        0

// reset values
`define PECR_RST_FORCE_LINK   1'b0
`define PECR_RST_JABBER_DIS   1'b0
`define PECR_RST_ECHO_DIS     1'b1
`define PECR_RST_SQE_DIS      1'b1
`define PECR_RST_SQUELCH      2'h0
`define PECR_RST_STICKY_EN    1'b1
`define PECR_RST_BCAST        1'b0

// squelch encodings
`define PECR_SQ_NORMAL        2'h0
`define PECR_SQ_LOW           2'h1
`define PECR_SQ_HIGH          2'h2

// mac_interface_control bits
`define PECR_MAC_CLKSRC       13
`define PECR_MAC_SEL_HI       12
`define PECR_MAC_SEL_LO       11
`define PECR_MAC_FAR_LOOP     3
`define PECR_RST_CLKSRC       1'b0
`define PECR_RST_MAC_SEL      2'h2
`define PECR_RST_FAR_LOOP     1'b0
`define PECR_MAC_GMII         2'h0
`define PECR_MAC_RMII         2'h1
`define PECR_MAC_RGMII        2'h2

// edge_jumbo_loop_control bits
`define PECR_EDGE_HI          15
`define PECR_EDGE_LO          13
`define PECR_EDGE_RPWR        12
`define PECR_JUMBO_HI         5
`define PECR_JUMBO_LO         4
`define PECR_EDGE_CONN_LOOP   0
`define PECR_RST_EDGE         3'h0
`define PECR_RST_RPWR         1'b0
`define PECR_RST_JUMBO        2'h0
`define PECR_RST_CONN_LOOP    1'b0
`define PECR_EDGE_SLOWEST     3'h3
`define PECR_EDGE_FASTEST     3'h4

// jumbo codes and length limits in bytes
`define PECR_JUMBO_NORMAL     2'h0
`define PECR_JUMBO_9K         2'h1
`define PECR_JUMBO_12K        2'h2
`define PECR_LEN_NORMAL       15'd1518
`define PECR_LEN_9K           15'd9216
`define PECR_LEN_12K          15'd12288
`define PECR_LEN_16K          15'd16383
// reference accuracy thresholds in ppm
`define PECR_PPM_BASE         8'd100
`define PECR_PPM_9K_EXT       8'd60
`define PECR_PPM_12K_EXT      8'd70

`endif

// File: rtl/pecr_ext_ctrl_regs.v
/*
 * pecr_ext_ctrl_regs.v: management registers 19 to 24 of the copper
 * transceiver: three saturating error counters, 10BASE-T control and
 * status, MAC interface select and edge/jumbo/loopback controls.
 * Assumes a management port front end on the same clock giving one-cycle
 * read/write strobes with a 5-bit register address, and event pulses from
 * the line logic on the same clock.
 */
`include "pecr_defs.vh"

// Operation
// - three counters: rx error, false carrier, disconnect
// - counters are 8 bits, saturate at 255
// - read returns count, then clears to zero
// - force-link bit forces 10BASE-T link pass
// - bit 14 disables jabber detect, resets 0
// - bit 13 disables echo, resets 1
// - bit 12 disables SIGNAL_QUALITY_ERROR_TEST test, resets 1
// - squelch field: normal, low, high; reset 00
// - sticky-reset enable keeps sticky bits on reset
// - super-sticky bits survive every software reset
// - EOF error flag sets, clears on read
// - 10BASE-T disconnect flag sets, clears on read
// - bit 6 shows live 10BASE-T link
// - broadcast bit applies writes in all PHYs
// - reads return only the addressed PHY
// - bit 13 picks receive clock source
// - MAC select: GMII, RMII, RGMII; reset 10
// - reads show mode in force, not pending
// - edge-rate field, sticky, resets 000
// - jumbo field selects maximum packet length
// - longer jumbo limits with better reference
module pecr_ext_ctrl_regs #(
  parameter [4:0] PHY_ADDR = 5'h00,
  parameter [7:0] REF_PPM  = 8'd100
) (
  // clock and reset
  input  wire        sys_clk_in,
  input  wire        rst_n_in,

  // management port access
  input  wire        mgmt_wr_in,
  input  wire        mgmt_rd_in,
  input  wire [4:0]  mgmt_phy_in,
  input  wire [4:0]  mgmt_reg_in,
  input  wire [15:0] mgmt_wdata_in,
  output reg  [15:0] mgmt_rdata_out,
  output reg         mgmt_rvalid_out,
  output wire        bcast_wr_out,

  // software reset and hold state
  input  wire        soft_reset_in,
  input  wire        global_hold_state_in,

  // line events, one-cycle pulses; ten_link_sm_in is a level
  input  wire        rx_err_evt_in,
  input  wire        false_carrier_evt_in,
  input  wire        link_disc_evt_in,
  input  wire        eof_err_evt_in,
  input  wire        ten_disc_evt_in,
  input  wire        ten_link_sm_in,

  // 10BASE-T controls
  output wire        ten_link_pass_out,
  output wire        jabber_det_dis_out,
  output wire        echo_dis_out,
  output wire        sqe_test_dis_out,
  output wire [1:0]  squelch_sel_out,

  // MAC interface mode
  output wire        rx_clk_ref_sel_out,
  output wire [1:0]  mac_if_sel_out,
  output wire        far_end_loop_out,

  // edge rate, jumbo and loopback
  output wire [2:0]  edge_rate_out,
  output wire        reduced_power_out,
  output wire [1:0]  jumbo_sel_out,
  output reg  [14:0] max_pkt_len_out,
  output wire        conn_loop_out
);

  // error counters
  reg  [7:0]  rxerr_cnt_r;
  reg  [7:0]  fcar_cnt_r;
  reg  [7:0]  ldisc_cnt_r;

  // register 22 controls and flags
  reg         force_link_r;
  reg         jabber_dis_r;
  reg         echo_dis_r;
  reg         sqe_dis_r;
  reg  [1:0]  squelch_r;
  reg         sticky_en_r;
  reg         eof_err_r;
  reg         ten_disc_r;
  reg         bcast_r;

  // register 23: written value and mode in force
  reg         clksrc_pend_r;
  reg  [1:0]  mac_sel_pend_r;
  reg         clksrc_r;
  reg  [1:0]  mac_sel_r;
  reg         far_loop_r;

  // register 24 controls
  reg  [2:0]  edge_r;
  reg         rpwr_r;
  reg  [1:0]  jumbo_r;
  reg         conn_loop_r;

  // combinational next values
  reg  [14:0] max_len_nxt;
  reg  [15:0] rdata_nxt;

  // broadcast reaches every PHY; reads stay addressed only
  wire addr_hit = (mgmt_phy_in == PHY_ADDR);
  wire wr_acc   = mgmt_wr_in & (addr_hit | bcast_r);
  wire rd_acc   = mgmt_rd_in & addr_hit;

  // per-register strobes
  wire rd_rx    = rd_acc & (mgmt_reg_in == `PECR_ADDR_RXERR_CNT);
  wire rd_fc    = rd_acc & (mgmt_reg_in == `PECR_ADDR_FCAR_CNT);
  wire rd_ld    = rd_acc & (mgmt_reg_in == `PECR_ADDR_LDISC_CNT);
  wire rd_ten   = rd_acc & (mgmt_reg_in == `PECR_ADDR_TEN_CTRL);
  wire wr_ten   = wr_acc & (mgmt_reg_in == `PECR_ADDR_TEN_CTRL);
  wire wr_mac   = wr_acc & (mgmt_reg_in == `PECR_ADDR_MAC_CTRL);
  wire wr_edge  = wr_acc & (mgmt_reg_in == `PECR_ADDR_EDGE_CTRL);

  // sticky bits fall back only when the enable is clear
  wire sticky_rst = soft_reset_in & ~sticky_en_r;

  assign bcast_wr_out = mgmt_wr_in & bcast_r;

  // saturating count; a read clears, an event on the same cycle
  // starts the new count at one so it is not lost
  function [7:0] cnt_next;
    input [7:0] cur;
    input       evt;
    input       rd;
    begin
      if (rd)
        cnt_next = evt ? 8'h01 : `PECR_CNT_RST;
      else if (evt && cur != `PECR_CNT_MAX)
        cnt_next = cur + 8'h01;
      else
        cnt_next = cur;
    end
  endfunction

  // counters see no software reset, only the hard reset
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      rxerr_cnt_r <= `PECR_CNT_RST;
    else
      rxerr_cnt_r <= cnt_next(rxerr_cnt_r, rx_err_evt_in, rd_rx);
  end

  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      fcar_cnt_r <= `PECR_CNT_RST;
    else
      fcar_cnt_r <= cnt_next(fcar_cnt_r, false_carrier_evt_in, rd_fc);
  end

  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      ldisc_cnt_r <= `PECR_CNT_RST;
    else
      ldisc_cnt_r <= cnt_next(ldisc_cnt_r, link_disc_evt_in, rd_ld);
  end

  // register 22 sticky controls
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      force_link_r <= `PECR_RST_FORCE_LINK;
      jabber_dis_r <= `PECR_RST_JABBER_DIS;
      echo_dis_r   <= `PECR_RST_ECHO_DIS;
      sqe_dis_r    <= `PECR_RST_SQE_DIS;
      squelch_r    <= `PECR_RST_SQUELCH;
      bcast_r      <= `PECR_RST_BCAST;
    end else if (sticky_rst) begin
      force_link_r <= `PECR_RST_FORCE_LINK;
      jabber_dis_r <= `PECR_RST_JABBER_DIS;
      echo_dis_r   <= `PECR_RST_ECHO_DIS;
      sqe_dis_r    <= `PECR_RST_SQE_DIS;
      squelch_r    <= `PECR_RST_SQUELCH;
      bcast_r      <= `PECR_RST_BCAST;
    end else if (wr_ten) begin
      force_link_r <= mgmt_wdata_in[`PECR_TEN_FORCE_LINK];
      jabber_dis_r <= mgmt_wdata_in[`PECR_TEN_JABBER_DIS];
      echo_dis_r   <= mgmt_wdata_in[`PECR_TEN_ECHO_DIS];
      sqe_dis_r    <= mgmt_wdata_in[`PECR_TEN_SQE_DIS];
      squelch_r    <= mgmt_wdata_in[`PECR_TEN_SQUELCH_HI:
                                    `PECR_TEN_SQUELCH_LO];
      bcast_r      <= mgmt_wdata_in[`PECR_TEN_BCAST];
    end
  end

  // super-sticky: only the hard reset returns it to default
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      sticky_en_r <= `PECR_RST_STICKY_EN;
    else if (wr_ten)
      sticky_en_r <= mgmt_wdata_in[`PECR_TEN_STICKY_EN];
  end

  // self-clearing event flags: a set in the read cycle wins
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      eof_err_r <= 1'b0;
    else
      eof_err_r <= eof_err_evt_in | (eof_err_r & ~rd_ten);
  end

  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      ten_disc_r <= 1'b0;
    else
      ten_disc_r <= ten_disc_evt_in | (ten_disc_r & ~rd_ten);
  end

  // register 23: written value waits until soft reset or hold state;
  // the pending copy survives soft reset, which is what applies it
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      clksrc_pend_r  <= `PECR_RST_CLKSRC;
      mac_sel_pend_r <= `PECR_RST_MAC_SEL;
    end else if (wr_mac) begin
      clksrc_pend_r  <= mgmt_wdata_in[`PECR_MAC_CLKSRC];
      mac_sel_pend_r <= mgmt_wdata_in[`PECR_MAC_SEL_HI:
                                      `PECR_MAC_SEL_LO];
    end
  end

  // mode in force; reads and outputs never show the pending copy
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      clksrc_r  <= `PECR_RST_CLKSRC;
      mac_sel_r <= `PECR_RST_MAC_SEL;
    end else if (soft_reset_in || global_hold_state_in) begin
      clksrc_r  <= clksrc_pend_r;
      mac_sel_r <= mac_sel_pend_r;
    end
  end

  // far-end loopback is not sticky: soft reset clears it
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      far_loop_r <= `PECR_RST_FAR_LOOP;
    else if (wr_mac)
      far_loop_r <= mgmt_wdata_in[`PECR_MAC_FAR_LOOP];
    else if (soft_reset_in)
      far_loop_r <= `PECR_RST_FAR_LOOP;
  end

  // register 24: edge, reduced power and jumbo are sticky
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      edge_r  <= `PECR_RST_EDGE;
      rpwr_r  <= `PECR_RST_RPWR;
      jumbo_r <= `PECR_RST_JUMBO;
    end else if (sticky_rst) begin
      edge_r  <= `PECR_RST_EDGE;
      rpwr_r  <= `PECR_RST_RPWR;
      jumbo_r <= `PECR_RST_JUMBO;
    end else if (wr_edge) begin
      edge_r  <= mgmt_wdata_in[`PECR_EDGE_HI:`PECR_EDGE_LO];
      rpwr_r  <= mgmt_wdata_in[`PECR_EDGE_RPWR];
      jumbo_r <= mgmt_wdata_in[`PECR_JUMBO_HI:`PECR_JUMBO_LO];
    end
  end

  // connector loopback is not sticky: soft reset clears it
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      conn_loop_r <= `PECR_RST_CONN_LOOP;
    else if (wr_edge)
      conn_loop_r <= mgmt_wdata_in[`PECR_EDGE_CONN_LOOP];
    else if (soft_reset_in)
      conn_loop_r <= `PECR_RST_CONN_LOOP;
  end

  // length limit; reserved code falls back to normal length
  always @* begin
    case (jumbo_r)
      `PECR_JUMBO_9K:
        max_len_nxt = (REF_PPM <= `PECR_PPM_9K_EXT) ?
                      `PECR_LEN_12K : `PECR_LEN_9K;
      `PECR_JUMBO_12K:
        max_len_nxt = (REF_PPM <= `PECR_PPM_12K_EXT) ?
                      `PECR_LEN_16K : `PECR_LEN_12K;
      default:
        max_len_nxt = `PECR_LEN_NORMAL;
    endcase
  end

  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      max_pkt_len_out <= `PECR_LEN_NORMAL;
    else
      max_pkt_len_out <= max_len_nxt;
  end

  // read mux; reserved positions and other addresses read zero
  always @* begin
    rdata_nxt = 16'h0000;
    case (mgmt_reg_in)
      `PECR_ADDR_RXERR_CNT: rdata_nxt[7:0] = rxerr_cnt_r;
      `PECR_ADDR_FCAR_CNT:  rdata_nxt[7:0] = fcar_cnt_r;
      `PECR_ADDR_LDISC_CNT: rdata_nxt[7:0] = ldisc_cnt_r;

      `PECR_ADDR_TEN_CTRL: begin
        rdata_nxt[`PECR_TEN_FORCE_LINK] = force_link_r;
        rdata_nxt[`PECR_TEN_JABBER_DIS] = jabber_dis_r;
        rdata_nxt[`PECR_TEN_ECHO_DIS]   = echo_dis_r;
        rdata_nxt[`PECR_TEN_SQE_DIS]    = sqe_dis_r;
        rdata_nxt[`PECR_TEN_SQUELCH_HI:`PECR_TEN_SQUELCH_LO] = squelch_r;
        rdata_nxt[`PECR_TEN_STICKY_EN]  = sticky_en_r;
        rdata_nxt[`PECR_TEN_EOF_ERR]    = eof_err_r;
        rdata_nxt[`PECR_TEN_DISC]       = ten_disc_r;
        rdata_nxt[`PECR_TEN_LINK]       = ten_link_pass_out;
        rdata_nxt[`PECR_TEN_BCAST]      = bcast_r;
      end

      `PECR_ADDR_MAC_CTRL: begin
        rdata_nxt[`PECR_MAC_CLKSRC]     = clksrc_r;
        rdata_nxt[`PECR_MAC_SEL_HI:`PECR_MAC_SEL_LO] = mac_sel_r;
        rdata_nxt[`PECR_MAC_FAR_LOOP]   = far_loop_r;
      end

      `PECR_ADDR_EDGE_CTRL: begin
        rdata_nxt[`PECR_EDGE_HI:`PECR_EDGE_LO] = edge_r;
        rdata_nxt[`PECR_EDGE_RPWR]      = rpwr_r;
        rdata_nxt[`PECR_JUMBO_HI:`PECR_JUMBO_LO] = jumbo_r;
        rdata_nxt[`PECR_EDGE_CONN_LOOP] = conn_loop_r;
      end

      default: rdata_nxt = 16'h0000;
    endcase
  end

  // read data registered; the clear-on-read acts in the same edge
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mgmt_rdata_out  <= 16'h0000;
      mgmt_rvalid_out <= 1'b0;
    end else begin
      mgmt_rvalid_out <= rd_acc;
      if (rd_acc)
        mgmt_rdata_out <= rdata_nxt;
    end
  end

  // force bypasses the integrity state machine
  assign ten_link_pass_out  = force_link_r | ten_link_sm_in;

  // register 22 line controls
  assign jabber_det_dis_out = jabber_dis_r;
  assign echo_dis_out       = echo_dis_r;
  assign sqe_test_dis_out   = sqe_dis_r;
  assign squelch_sel_out    = squelch_r;

  // clock source has no meaning in reduced-pin mode
  assign rx_clk_ref_sel_out = clksrc_r & (mac_sel_r != `PECR_MAC_RMII);
  assign mac_if_sel_out     = mac_sel_r;
  assign far_end_loop_out   = far_loop_r;

  // register 24 controls
  assign edge_rate_out      = edge_r;
  assign reduced_power_out  = rpwr_r;
  assign jumbo_sel_out      = jumbo_r;
  assign conn_loop_out      = conn_loop_r;

endmodule // pecr_ext_ctrl_regs

// File: sim/pecr_checker.sv
/* pecr_checker.sv: port assertions for the extended register bank.
   Assumes the bank's port names; bound in after the module. */
module pecr_checker #(
  parameter [4:0] PHY_ADDR = 5'h00,
  parameter [7:0] REF_PPM  = 8'd100
) (
  // clock, reset, management port
  input wire        sys_clk_in,
  input wire        rst_n_in,
  input wire        mgmt_wr_in,
  input wire        mgmt_rd_in,
  input wire [4:0]  mgmt_phy_in,
  input wire [4:0]  mgmt_reg_in,
  input wire [15:0] mgmt_wdata_in,
  input wire [15:0] mgmt_rdata_out,
  input wire        mgmt_rvalid_out,
  input wire        bcast_wr_out,
  input wire        soft_reset_in,
  input wire        global_hold_state_in,
  // controls
  input wire        ten_link_pass_out,
  input wire [1:0]  mac_if_sel_out,
  input wire [1:0]  jumbo_sel_out,
  input wire [14:0] max_pkt_len_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  wire        own = mgmt_phy_in == PHY_ADDR;
  // reserved jumbo code has no limit of its own, so it is skipped
  wire [14:0] len_exp = jumbo_sel_out == 2'h1 ?
    (REF_PPM <= 8'd60 ? 15'd12288 : 15'd9216) : jumbo_sel_out == 2'h2 ?
    (REF_PPM <= 8'd70 ? 15'd16383 : 15'd12288) : 15'd1518;

  sequence s_wr(logic [4:0] a);
    mgmt_wr_in && own && mgmt_reg_in == a && !soft_reset_in &&
      !global_hold_state_in;
  endsequence

  a_rd_answer: assert property (
    mgmt_rd_in && own |=> mgmt_rvalid_out) else $error("read unanswered");
  a_rd_refused: assert property (
    !(mgmt_rd_in && own) |=> !mgmt_rvalid_out) else $error("stray rvalid");
  a_cnt_upper: assert property (
    mgmt_rd_in && own && mgmt_reg_in inside {[5'h13:5'h15]}
    |=> mgmt_rdata_out[15:8] == 8'h00) else $error("counter high byte");
  a_unmapped_zero: assert property (
    mgmt_rd_in && own && !(mgmt_reg_in inside {[5'h13:5'h18]})
    |=> mgmt_rdata_out == 16'h0000) else $error("unmapped not zero");
  a_force_link: assert property (
    s_wr(5'h16) ##0 mgmt_wdata_in[15] |=> ten_link_pass_out)
    else $error("forced link not passing");
  a_bcast_fwd: assert property (
    s_wr(5'h16) ##0 mgmt_wdata_in[0] ##1 (!mgmt_wr_in && !soft_reset_in)[*4]
    ##1 mgmt_wr_in |-> bcast_wr_out) else $error("broadcast missing");
  a_mode_hold: assert property (
    s_wr(5'h17) |=> $stable(mac_if_sel_out)) else $error("mode early");
  a_mode_apply: assert property (
    s_wr(5'h17) ##0 mgmt_wdata_in[12:11] != 2'h3 ##1 !mgmt_wr_in
    ##1 soft_reset_in && !mgmt_wr_in
    |=> mac_if_sel_out == $past(mgmt_wdata_in[12:11], 3))
    else $error("mode not applied");
  a_jumbo_len: assert property (
    jumbo_sel_out != 2'h3 && jumbo_sel_out == $past(jumbo_sel_out)
    |-> max_pkt_len_out == len_exp) else $error("packet limit wrong");
endmodule // pecr_checker

bind pecr_ext_ctrl_regs pecr_checker #(
  .PHY_ADDR(PHY_ADDR),
  .REF_PPM(REF_PPM)
) u_pecr_checker (
  .sys_clk_in, .rst_n_in, .mgmt_wr_in, .mgmt_rd_in, .mgmt_phy_in,
  .mgmt_reg_in, .mgmt_wdata_in, .mgmt_rdata_out, .mgmt_rvalid_out,
  .bcast_wr_out, .soft_reset_in, .global_hold_state_in,
  .ten_link_pass_out, .mac_if_sel_out, .jumbo_sel_out, .max_pkt_len_out
);

// File: sim/pecr_smi_model.sv
/* pecr_smi_model.sv: management controller model for the bank.
   Assumes the bank's clock; requests move 1 ns after a rising edge. */
module pecr_smi_model (
  // clock
  input  wire         sys_clk_in,
  // requests
  output logic        mgmt_wr_out,
  output logic        mgmt_rd_out,
  output logic [4:0]  mgmt_phy_out,
  output logic [4:0]  mgmt_reg_out,
  output logic [15:0] mgmt_wdata_out,
  output logic        soft_reset_out,
  // answers
  input  wire [15:0]  mgmt_rdata_in,
  input  wire         mgmt_rvalid_in
);
  timeunit 1ns;
  timeprecision 100ps;
  int gap = 0;

  initial begin
    mgmt_wr_out = 1'b0;
    mgmt_rd_out = 1'b0;
    mgmt_phy_out = 5'h00;
    mgmt_reg_out = 5'h00;
    mgmt_wdata_out = 16'h0000;
    soft_reset_out = 1'b0;
  end

  // idle cycles first, so the bank also meets a slow master
  task automatic strobe(input logic w, input logic [4:0] p, r,
                        input logic [15:0] d);
    repeat (gap + 1) @(posedge sys_clk_in);
    #1 mgmt_wr_out = w;
    mgmt_rd_out = !w;
    mgmt_phy_out = p;
    mgmt_reg_out = r;
    mgmt_wdata_out = d;
    @(posedge sys_clk_in);
    #1 mgmt_wr_out = 1'b0;
    mgmt_rd_out = 1'b0;
    // released data must not keep its last value
    mgmt_wdata_out = ~d;
  endtask

  task automatic wr(input logic [4:0] p, r, input logic [15:0] d);
    strobe(1'b1, p, r, d);
  endtask

  task automatic rd(input logic [4:0] p, r, output logic [15:0] d,
                    output logic v);
    strobe(1'b0, p, r, 16'h0000);
    v = mgmt_rvalid_in;
    d = mgmt_rdata_in;
  endtask

  // mode bits of the interface register change through this or global_hold_state_in
  task automatic soft_rst;
    @(posedge sys_clk_in);
    #1 soft_reset_out = 1'b1;
    @(posedge sys_clk_in);
    #1 soft_reset_out = 1'b0;
  endtask
endmodule // pecr_smi_model

// File: sim/phy_ext_ctrl_counter_regs_tb_top.sv
/* phy_ext_ctrl_counter_regs_tb_top.sv: self-checking bench for the
   register bank. Assumes the controller model and the bound checker. */
module phy_ext_ctrl_counter_regs_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
`define CHK(n, e, s) chk(n, e, s)
  localparam logic [4:0] PHY = 5'h02;
  logic        sys_clk_in, rst_n_in, soft_reset_in, global_hold_state_in;
  logic        mgmt_wr_in, mgmt_rd_in, mgmt_rvalid_out, bcast_wr_out;
  logic [4:0]  mgmt_phy_in, mgmt_reg_in, evt;
  logic [15:0] mgmt_wdata_in, mgmt_rdata_out, d;
  logic        ten_link_sm_in, ten_link_pass_out, rx_clk_ref_sel_out, v;
  logic        jabber_det_dis_out, echo_dis_out, sqe_test_dis_out;
  logic        far_end_loop_out, reduced_power_out, conn_loop_out;
  logic [1:0]  squelch_sel_out, mac_if_sel_out, jumbo_sel_out;
  logic [2:0]  edge_rate_out;
  logic [14:0] max_pkt_len_out;
  int          mismatches, samples_checked, i;
  logic [15:0] lens [3] = '{16'd1518, 16'd9216, 16'd12288};

  pecr_ext_ctrl_regs #(.PHY_ADDR(PHY), .REF_PPM(8'd100)) dut (
    .sys_clk_in, .rst_n_in, .mgmt_wr_in, .mgmt_rd_in, .mgmt_phy_in,
    .mgmt_reg_in, .mgmt_wdata_in, .mgmt_rdata_out, .mgmt_rvalid_out,
    .bcast_wr_out, .soft_reset_in, .global_hold_state_in,
    .rx_err_evt_in(evt[4]), .false_carrier_evt_in(evt[3]),
    .link_disc_evt_in(evt[2]), .eof_err_evt_in(evt[1]),
    .ten_disc_evt_in(evt[0]), .ten_link_sm_in, .ten_link_pass_out,
    .jabber_det_dis_out, .echo_dis_out, .sqe_test_dis_out,
    .squelch_sel_out, .rx_clk_ref_sel_out, .mac_if_sel_out,
    .far_end_loop_out, .edge_rate_out, .reduced_power_out,
    .jumbo_sel_out, .max_pkt_len_out, .conn_loop_out);
  pecr_smi_model smi (
    .sys_clk_in, .mgmt_wr_out(mgmt_wr_in), .mgmt_rd_out(mgmt_rd_in),
    .mgmt_phy_out(mgmt_phy_in), .mgmt_reg_out(mgmt_reg_in),
    .mgmt_wdata_out(mgmt_wdata_in), .soft_reset_out(soft_reset_in),
    .mgmt_rdata_in(mgmt_rdata_out), .mgmt_rvalid_in(mgmt_rvalid_out));

  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end

  task automatic chk(string n, logic [15:0] e, s);
    samples_checked++;
    if (s !== e) begin
      $display("ERROR %s expected %h seen %h", n, e, s);
      mismatches++;
    end
  endtask

  task automatic rdchk(logic [4:0] r, logic [15:0] e, string n);
    smi.rd(PHY, r, d, v);
    `CHK("rvalid", 16'h0001, {15'h0, v});
    `CHK(n, e, d);
  endtask

  task automatic fire(logic [4:0] m, int n);
    repeat (n) begin
      @(posedge sys_clk_in);
      #1 evt = m;
      @(posedge sys_clk_in);
      #1 evt = 5'h00;
    end
  endtask

  task automatic t_reset;
    for (i = 0; i < 3; i++) rdchk(5'(5'h13 + i), 16'h0000, "cnt");
    rdchk(5'h16, 16'h3200, "ten_ctrl");
    rdchk(5'h17, 16'h1000, "mac_ctrl");
    rdchk(5'h18, 16'h0000, "edge_ctrl");
    rdchk(5'h1f, 16'h0000, "unmapped");
  endtask

  task automatic t_count;
    fire(5'h1c, 3);
    for (i = 0; i < 3; i++) begin
      rdchk(5'(5'h13 + i), 16'h0003, "cnt");
      rdchk(5'(5'h13 + i), 16'h0000, "cnt_clr");
    end
    fire(5'h1c, 260);
    for (i = 0; i < 3; i++) rdchk(5'(5'h13 + i), 16'h00ff, "sat");
  endtask

  task automatic t_ten;
    for (i = 0; i < 3; i++) begin
      smi.wr(PHY, 5'h16, 16'(i << 10) | 16'h3200);
      `CHK("squelch", 16'(i), {14'h0, squelch_sel_out});
      `CHK("no_pass", 16'h0, {15'h0, ten_link_pass_out});
    end
    smi.wr(PHY, 5'h16, 16'hf7fe);
    `CHK("pass", 16'h1, {15'h0, ten_link_pass_out});
    `CHK("dis", 16'h7, {13'h0, jabber_det_dis_out, echo_dis_out,
      sqe_test_dis_out});
    rdchk(5'h16, 16'hf640, "ten_ro");
    fire(5'h03, 1);
    ten_link_sm_in = 1'b1;
    rdchk(5'h16, 16'hf7c0, "flags");
    rdchk(5'h16, 16'hf640, "flags_clr");
    ten_link_sm_in = 1'b0;
  endtask

  task automatic t_sticky;
    for (i = 0; i < 3; i++) begin
      smi.wr(PHY, 5'h18, 16'(i << 4));
      repeat (2) @(posedge sys_clk_in);
      #1 `CHK("len", lens[i], {1'b0, max_pkt_len_out});
    end
    smi.wr(PHY, 5'h18, 16'h6000);
    `CHK("slow", 16'h3, {13'h0, edge_rate_out});
    smi.wr(PHY, 5'h18, 16'h8000);
    `CHK("fast", 16'h4, {13'h0, edge_rate_out});
    smi.wr(PHY, 5'h18, 16'h7fdf);
    `CHK("rpwr_conn", 16'h3, {14'h0, reduced_power_out, conn_loop_out});
    rdchk(5'h18, 16'h7011, "edge_rsvd");
    smi.soft_rst;
    `CHK("kept_out", 16'h2, {14'h0, reduced_power_out, conn_loop_out});
    rdchk(5'h18, 16'h7010, "edge_kept");
    rdchk(5'h16, 16'hf640, "ten_kept");
    smi.wr(PHY, 5'h16, 16'hf400);
    smi.soft_rst;
    rdchk(5'h16, 16'h3000, "ten_dflt");
    rdchk(5'h18, 16'h0000, "edge_dflt");
  endtask

  task automatic t_mode;
    for (i = 0; i < 3; i++) begin
      smi.wr(PHY, 5'h17, 16'(i << 11) | 16'h0008);
      `CHK("far_loop", 16'h1, {15'h0, far_end_loop_out});
      smi.soft_rst;
      `CHK("far_clr", 16'h0, {15'h0, far_end_loop_out});
      `CHK("mac_sel", 16'(i), {14'h0, mac_if_sel_out});
    end
    rdchk(5'h17, 16'h1000, "mac_rgmii");
    smi.wr(PHY, 5'h17, 16'h2000);
    rdchk(5'h17, 16'h1000, "mac_pend");
    @(posedge sys_clk_in);
    #1 global_hold_state_in = 1'b1;
    @(posedge sys_clk_in);
    #1 global_hold_state_in = 1'b0;
    rdchk(5'h17, 16'h2000, "mac_hold");
    `CHK("ref_clk", 16'h1, {15'h0, rx_clk_ref_sel_out});
  endtask

  task automatic t_bcast;
    smi.gap = 3;
    smi.wr(PHY, 5'h16, 16'h3001);
    smi.wr(5'h05, 5'h18, 16'h8000);
    rdchk(5'h18, 16'h8000, "bcast_on");
    smi.rd(5'h05, 5'h18, d, v);
    `CHK("other_rd", 16'h0, {15'h0, v});
    smi.wr(PHY, 5'h16, 16'h3000);
    smi.wr(5'h05, 5'h18, 16'h0000);
    rdchk(5'h18, 16'h8000, "bcast_off");
    smi.gap = 0;
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge sys_clk_in);
    mismatches++;
    results;
  end

  initial begin
    rst_n_in = 1'b0;
    global_hold_state_in = 1'b0;
    ten_link_sm_in = 1'b0;
    evt = 5'h00;
    mismatches = 0;
    samples_checked = 0;
    repeat (20) @(posedge sys_clk_in);
    #1 rst_n_in = 1'b1;
    t_reset;
    t_count;
    t_ten;
    t_sticky;
    t_mode;
    t_bcast;
    results;
  end
endmodule // phy_ext_ctrl_counter_regs_tb_top
